// ==== logic/wdc_regs.vh ====
`ifndef WDC_REGS_VH
`define WDC_REGS_VH

// register indices; byte address is four times the index
`define WDC_IDX_CTRL 12'hff0
`define WDC_IDX_UPPER 12'hff1
`define WDC_IDX_HIGH 12'hff2
`define WDC_IDX_LOW 12'hff3
`define WDC_IDX_REFRESH 12'hff4

// unlock codes written to the control index
`define WDC_UNLOCK_FIRST 8'h55
`define WDC_UNLOCK_SECOND 8'haa

// status byte layout at the control index (read side)
`define WDC_STAT_TIMEOUT 7
`define WDC_STAT_SLEEP 6
`define WDC_STAT_ENABLED 5

// reload and counter values
`define WDC_RELOAD_RESET 24'h000400
`define WDC_COUNT_MAX 24'hffffff
`define WDC_NO_REFRESH_AT 24'h000002
`define WDC_TIMEOUT_AT 24'h000001

// timing: oscillator rate and system clock rate in hertz
`define WDC_RC_FREQ_HZ 10000
`define WDC_SYS_FREQ_HZ 10000000
`define WDC_TICK_CYCLES (`WDC_SYS_FREQ_HZ / `WDC_RC_FREQ_HZ)

`endif

// ==== logic/wdc_watchdog.v ====
`timescale 1ns/1ps
`include "wdc_regs.vh"

module wdc_watchdog #(
   parameter TICK_CYCLES = `WDC_TICK_CYCLES
) (
   input wire clock,
   input wire resetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output wire hreadyout,
   output wire hresp,
   output wire [31:0] hrdata,
   input wire always_on_option,
   input wire timeout_response_option,
   input wire stop_mode,
   output wire wdt_irq_req,
   output wire sys_reset_req,
   output wire stop_recovery_req
);

   // lock sequence states
   localparam [2:0] LK_IDLE = 3'd0;
   localparam [2:0] LK_GOT55 = 3'd1;
   localparam [2:0] LK_OPEN = 3'd2;
   localparam [2:0] LK_GOTU = 3'd3;
   localparam [2:0] LK_GOTH = 3'd4;

   // divider end point; the counter is 16 bits, so the top of the difference is cut on purpose
   localparam [31:0] TICK_FULL = TICK_CYCLES - 1;
   localparam [15:0] TICK_LAST = TICK_FULL[15:0];

   // index match on the word address
   function hit;
      input [11:0] idx;
      input [11:0] want;
      begin
         hit = (idx == want);
      end
   endfunction

   reg dp_wr_r;
   reg [11:0] dp_idx_r;
   reg [31:0] hrdata_r;
   reg [2:0] lock_r;
   reg [2:0] lock_nxt;
   reg [7:0] stage_u_r;
   reg [7:0] stage_h_r;
   reg [23:0] reload_r;
   reg [23:0] count_r;
   reg [23:0] count_nxt;
   reg enabled_r;
   reg strap_done_r;
   reg resp_reset_r;
   reg [15:0] div_r;
   reg flag_to_r;
   reg flag_sleep_r;
   reg irq_r;
   reg rst_r;
   reg rec_r;

   wire ap_valid;
   wire rd_acc;
   wire [11:0] ap_idx;
   wire [7:0] wbyte;
   wire wr_ctrl;
   wire wr_upper;
   wire wr_high;
   wire wr_low;
   wire refresh_evt;
   wire ao_evt;
   wire resp_reset;
   wire tick;
   wire refresh_ok;
   wire timeout_evt;
   wire status_rd;

   // zero-wait slave: every transfer completes in its first data cycle
   assign hreadyout = 1'b1;
   assign hresp = 1'b0;
   assign hrdata = hrdata_r;

   assign ap_valid = hsel & hready & htrans[1];
   assign rd_acc = ap_valid & ~hwrite;
   assign ap_idx = haddr[13:2];
   assign wbyte = hwdata[7:0];

   // writes act in the data phase, when hwdata is valid
   assign wr_ctrl = dp_wr_r & hit(dp_idx_r, `WDC_IDX_CTRL);
   assign wr_upper = dp_wr_r & hit(dp_idx_r, `WDC_IDX_UPPER);
   assign wr_high = dp_wr_r & hit(dp_idx_r, `WDC_IDX_HIGH);
   assign wr_low = dp_wr_r & hit(dp_idx_r, `WDC_IDX_LOW);
   assign refresh_evt = dp_wr_r & hit(dp_idx_r, `WDC_IDX_REFRESH);
   assign status_rd = rd_acc & hit(ap_idx, `WDC_IDX_CTRL);

   // bus address phase capture
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         dp_wr_r <= 1'b0;
         dp_idx_r <= 12'h000;
      end else begin
         dp_wr_r <= ap_valid & hwrite;
         dp_idx_r <= ap_idx;
      end
   end

   // read data is latched at the address phase so it stands in the data phase
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         hrdata_r <= 32'h00000000;
      end else if (rd_acc) begin
         hrdata_r <= 32'h00000000;
         if (hit(ap_idx, `WDC_IDX_CTRL)) begin
            hrdata_r[`WDC_STAT_TIMEOUT] <= flag_to_r;
            hrdata_r[`WDC_STAT_SLEEP] <= flag_sleep_r;
            hrdata_r[`WDC_STAT_ENABLED] <= enabled_r;
         end else if (hit(ap_idx, `WDC_IDX_UPPER)) begin
            hrdata_r[7:0] <= count_r[23:16];
         end else if (hit(ap_idx, `WDC_IDX_HIGH)) begin
            hrdata_r[7:0] <= count_r[15:8];
         end else if (hit(ap_idx, `WDC_IDX_LOW)) begin
            hrdata_r[7:0] <= count_r[7:0];
         end
      end
   end

   // lock sequence; any write that breaks the order drops back to idle, except 55h to the control index, which restarts it
   always @* begin
      lock_nxt = lock_r;
      if (dp_wr_r) begin
         lock_nxt = LK_IDLE;
         case (lock_r)
            LK_IDLE: begin
               if (wr_ctrl && wbyte == `WDC_UNLOCK_FIRST)
                  lock_nxt = LK_GOT55;
            end
            LK_GOT55: begin
               if (wr_ctrl && wbyte == `WDC_UNLOCK_SECOND)
                  lock_nxt = LK_OPEN;
               else if (wr_ctrl && wbyte == `WDC_UNLOCK_FIRST)
                  lock_nxt = LK_GOT55;
            end
            LK_OPEN: begin
               if (wr_upper)
                  lock_nxt = LK_GOTU;
            end
            LK_GOTU: begin
               if (wr_high)
                  lock_nxt = LK_GOTH;
            end
            LK_GOTH: begin
               lock_nxt = LK_IDLE;
            end
            default: begin
               lock_nxt = LK_IDLE;
            end
         endcase
         // a fresh 55h always restarts the sequence
         if (lock_r != LK_GOT55 && wr_ctrl && wbyte == `WDC_UNLOCK_FIRST)
            lock_nxt = LK_GOT55;
      end
   end

   // control writes carry no stored bits: only the lock state moves
   always @(posedge clock or negedge resetn) begin
      if (!resetn)
         lock_r <= LK_IDLE;
      else
         lock_r <= lock_nxt;
   end

   // reload bytes are staged and committed together on the low byte write,
   // so a refresh in mid-sequence never loads a half-updated value
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         stage_u_r <= 8'h00;
         stage_h_r <= 8'h00;
         reload_r <= `WDC_RELOAD_RESET;
      end else begin
         if (wr_upper && lock_r == LK_OPEN)
            stage_u_r <= wbyte;
         if (wr_high && lock_r == LK_GOTU)
            stage_h_r <= wbyte;
         if (wr_low && lock_r == LK_GOTH)
            reload_r <= {stage_u_r, stage_h_r, wbyte};
      end
   end

   // option straps are caught on the first edge after reset release
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         strap_done_r <= 1'b0;
         resp_reset_r <= 1'b0;
      end else if (!strap_done_r) begin
         strap_done_r <= 1'b1;
         resp_reset_r <= timeout_response_option;
      end
   end

   assign ao_evt = ~strap_done_r & always_on_option & ~enabled_r;
   assign resp_reset = strap_done_r ? resp_reset_r : timeout_response_option;

   // oscillator tick from a divider; no debug input stops it
   always @(posedge clock or negedge resetn) begin
      if (!resetn)
         div_r <= 16'h0000;
      else if (div_r == TICK_LAST)
         div_r <= 16'h0000;
      else
         div_r <= div_r + 16'h0001;
   end

   assign tick = (div_r == TICK_LAST);

   // refresh is refused once the count is down to two
   assign refresh_ok = refresh_evt &
                       (~enabled_r | (count_r > `WDC_NO_REFRESH_AT));
   assign timeout_evt = enabled_r & tick & ~refresh_ok &
                        (count_r <= `WDC_TIMEOUT_AT);

   // next count: load, refresh, reload (reset mode) or wrap (interrupt mode) after time-out, or step down
   always @* begin
      count_nxt = count_r;
      if (refresh_ok || ao_evt) begin
         count_nxt = reload_r;
      end else if (enabled_r && tick) begin
         if (count_r <= `WDC_TIMEOUT_AT) begin
            if (resp_reset)
               count_nxt = reload_r;
            else
               count_nxt = `WDC_COUNT_MAX;
         end else begin
            count_nxt = count_r - 24'h000001;
         end
      end
   end

   // counter and enable; nothing but reset clears the enable
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         count_r <= `WDC_RELOAD_RESET;
         enabled_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         if (refresh_evt || ao_evt)
            enabled_r <= 1'b1;
      end
   end

   // status flags: a time-out in the same cycle as a status read wins
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         flag_to_r <= 1'b0;
         flag_sleep_r <= 1'b0;
      end else begin
         if (timeout_evt)
            flag_to_r <= 1'b1;
         else if (status_rd)
            flag_to_r <= 1'b0;
         if (timeout_evt && stop_mode)
            flag_sleep_r <= 1'b1;
         else if (status_rd)
            flag_sleep_r <= 1'b0;
      end
   end

   // time-out responses, one-cycle pulses from flip-flops
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         irq_r <= 1'b0;
         rst_r <= 1'b0;
         rec_r <= 1'b0;
      end else begin
         irq_r <= timeout_evt & ~resp_reset;
         rst_r <= timeout_evt & resp_reset & ~stop_mode;
         rec_r <= timeout_evt & stop_mode;
      end
   end

   assign wdt_irq_req = irq_r;
   assign sys_reset_req = rst_r;
   assign stop_recovery_req = rec_r;

endmodule

// ==== bench/wdc_chk.sv ====
`timescale 1ns/1ps
module wdc_chk #(
   parameter TICK_CYCLES = 4
) (
   input wire clock,
   input wire resetn,
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire hreadyout,
   input wire hresp,
   input wire [31:0] hrdata,
   input wire timeout_response_option,
   input wire stop_mode,
   input wire wdt_irq_req,
   input wire sys_reset_req,
   input wire stop_recovery_req
);
   default clocking @(posedge clock); endclocking
   default disable iff (!resetn);
   // a read of index zero, which nothing decodes
   sequence s_rd_none;
      hsel && htrans[1] && !hwrite && haddr[13:2] == 12'h000;
   endsequence
   // a new time-out needs a tick, and ticks come four cycles apart, so three quiet cycles always hold
   sequence s_irq_quiet;
      !wdt_irq_req [*3];
   endsequence
   sequence s_rst_quiet;
      !sys_reset_req [*3];
   endsequence
   a_bus_okay: assert property (hreadyout && !hresp)
      else $error("bus not ready or not okay");
   a_rdata_byte: assert property (hrdata[31:8] == 24'h0)
      else $error("read data above byte not zero");
   a_none_zero: assert property (s_rd_none |=> hrdata == 32'h0)
      else $error("unmapped read not zero");
   a_irq_single: assert property (wdt_irq_req |=> s_irq_quiet)
      else $error("interrupt request not a single pulse");
   a_rst_single: assert property (sys_reset_req |=> s_rst_quiet)
      else $error("reset request not a single pulse");
   a_irq_mode: assert property (wdt_irq_req |-> !timeout_response_option)
      else $error("interrupt in reset mode");
   a_rst_run: assert property (sys_reset_req |-> timeout_response_option && !$past(stop_mode))
      else $error("reset request in wrong mode");
   a_rec_stop: assert property (stop_recovery_req |-> $past(stop_mode) && !sys_reset_req)
      else $error("recovery request outside stop");
   a_stop_irq: assert property (stop_recovery_req && !timeout_response_option |-> wdt_irq_req)
      else $error("stop recovery without interrupt");
endmodule
bind wdc_watchdog wdc_chk #(.TICK_CYCLES(TICK_CYCLES)) u_chk (.clock(clock), .resetn(resetn),
   .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hreadyout(hreadyout),
   .hresp(hresp), .hrdata(hrdata), .timeout_response_option(timeout_response_option),
   .stop_mode(stop_mode), .wdt_irq_req(wdt_irq_req), .sys_reset_req(sys_reset_req),
   .stop_recovery_req(stop_recovery_req));

// ==== bench/wdc_cpu_model.sv ====
`timescale 1ns/1ps
module wdc_cpu_model (
   input wire clock,
   input wire resetn,
   input wire stop_cmd,
   input wire wdt_irq_req,
   input wire sys_reset_req,
   input wire stop_recovery_req,
   output reg stop_mode,
   output reg [7:0] rst_count
);
   // stop is left only through a recovery request, as the real core does
   always @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         stop_mode <= 1'b0;
         rst_count <= 8'h00;
      end else begin
         if (stop_recovery_req) stop_mode <= 1'b0;
         else if (stop_cmd) stop_mode <= 1'b1;
         if (sys_reset_req) rst_count <= rst_count + 8'h01;
      end
   end
endmodule

// ==== bench/wdc_watchdog_tb.sv ====
`timescale 1ns/1ps
`include "wdc_regs.vh"
module wdc_watchdog_tb;
   reg clock = 1'b0;
   reg resetn = 1'b0;
   reg hsel = 1'b0;
   reg [31:0] haddr = 32'h0;
   reg [1:0] htrans = 2'b00;
   reg hwrite = 1'b0;
   reg [31:0] hwdata = 32'h0;
   reg ao = 1'b0;
   reg resp = 1'b0;
   reg stop_cmd = 1'b0;
   reg [31:0] rd;
   wire hreadyout, hresp, irq, srst, srec, stop_mode;
   wire [31:0] hrdata;
   wire [7:0] rst_count;
   integer mismatches = 0;
   integer checked = 0;
   integer n;
   // short tick keeps every time-out within a few thousand cycles
   wdc_watchdog #(.TICK_CYCLES(4)) u_dut (.clock(clock), .resetn(resetn), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010), .hwdata(hwdata),
      .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
      .always_on_option(ao), .timeout_response_option(resp), .stop_mode(stop_mode),
      .wdt_irq_req(irq), .sys_reset_req(srst), .stop_recovery_req(srec));
   wdc_cpu_model u_cpu (.clock(clock), .resetn(resetn), .stop_cmd(stop_cmd),
      .wdt_irq_req(irq), .sys_reset_req(srst), .stop_recovery_req(srec),
      .stop_mode(stop_mode), .rst_count(rst_count));
   always #50 clock = ~clock;
   task chk(input [31:0] got, input [31:0] exp);
      begin
         checked = checked + 1;
         if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
         end
      end
   endtask
   // one single transfer; read data lands in rd at the data phase edge
   task xfer(input w, input [11:0] idx, input [7:0] wd);
      begin
         @(posedge clock);
         hsel <= 1'b1;
         htrans <= 2'b10;
         haddr <= {18'h0, idx, 2'b00};
         hwrite <= w;
         @(posedge clock);
         while (hreadyout !== 1'b1) @(posedge clock);
         hsel <= 1'b0;
         htrans <= 2'b00;
         hwdata <= {24'h0, wd};
         @(posedge clock);
         while (hreadyout !== 1'b1) @(posedge clock);
         rd = hrdata;
      end
   endtask
   task rst(input a, input r);
      begin
         resetn <= 1'b0;
         ao <= a;
         resp <= r;
         repeat (6) @(posedge clock);
         resetn <= 1'b1;
      end
   endtask
   // software never programs below four
   task reload(input [23:0] v);
      begin
         xfer(1, `WDC_IDX_CTRL, 8'h55);
         xfer(1, `WDC_IDX_CTRL, 8'haa);
         xfer(1, `WDC_IDX_UPPER, v[23:16]);
         xfer(1, `WDC_IDX_HIGH, v[15:8]);
         xfer(1, `WDC_IDX_LOW, v[7:0]);
      end
   endtask
   task wait_pulse(input integer lim);
      begin
         n = 0;
         do begin
            @(posedge clock);
            n = n + 1;
         end while (!(irq === 1'b1 || srst === 1'b1 || srec === 1'b1) && n < lim);
      end
   endtask
   task t_off;
      begin
         rst(0, 0);
         repeat (20) @(posedge clock);
         xfer(0, `WDC_IDX_HIGH, 0); chk(rd, 32'h04);
         xfer(0, `WDC_IDX_LOW, 0); chk(rd, 32'h00);
         xfer(0, `WDC_IDX_CTRL, 0); chk(rd, 32'h00);
         xfer(0, 12'h000, 0); chk(rd, 32'h00);
         xfer(1, `WDC_IDX_UPPER, 8'h07);
         xfer(1, `WDC_IDX_REFRESH, 0);
         xfer(0, `WDC_IDX_UPPER, 0); chk(rd, 32'h00);
         xfer(0, `WDC_IDX_HIGH, 0); chk(rd, 32'h03);
         xfer(0, `WDC_IDX_CTRL, 0); chk(rd, 32'h20);
         $display("test off done");
      end
   endtask
   task t_lock;
      begin
         rst(0, 0);
         reload(24'h020580);
         xfer(1, `WDC_IDX_REFRESH, 0);
         xfer(0, `WDC_IDX_UPPER, 0); chk(rd, 32'h02);
         xfer(0, `WDC_IDX_HIGH, 0); chk(rd, 32'h05);
         xfer(0, `WDC_IDX_CTRL, 0); chk(rd, 32'h20);
         xfer(1, `WDC_IDX_CTRL, 8'h55);
         xfer(1, `WDC_IDX_CTRL, 8'haa);
         xfer(1, `WDC_IDX_UPPER, 8'h00);
         xfer(1, 12'h000, 8'h00);
         xfer(1, `WDC_IDX_HIGH, 8'h00);
         xfer(1, `WDC_IDX_LOW, 8'h10);
         xfer(1, `WDC_IDX_REFRESH, 0);
         xfer(0, `WDC_IDX_UPPER, 0); chk(rd, 32'h02);
         $display("test lock done");
      end
   endtask
   task t_irq;
      begin
         rst(0, 0);
         reload(24'h000004);
         xfer(1, `WDC_IDX_REFRESH, 0);
         wait_pulse(60);
         chk(n >= 12 && n <= 20, 1);
         chk({srst, srec, irq}, 3'b001);
         xfer(0, `WDC_IDX_UPPER, 0); chk(rd, 32'hff);
         xfer(0, `WDC_IDX_CTRL, 0); chk(rd, 32'ha0);
         xfer(0, `WDC_IDX_CTRL, 0); chk(rd, 32'h20);
         reload(24'h000040);
         xfer(1, `WDC_IDX_REFRESH, 0);
         n = 0;
         do begin
            xfer(0, `WDC_IDX_LOW, 0);
            n = n + 1;
         end while (rd[7:0] > 8'h02 && n < 200);
         xfer(1, `WDC_IDX_REFRESH, 0);
         wait_pulse(40);
         chk(irq, 1'b1);
         $display("test irq done");
      end
   endtask
   task t_stop_irq;
      begin
         rst(0, 0);
         reload(24'h000004);
         xfer(1, `WDC_IDX_REFRESH, 0);
         stop_cmd <= 1'b1;
         @(posedge clock);
         stop_cmd <= 1'b0;
         wait_pulse(60);
         chk({srst, srec, irq}, 3'b011);
         xfer(0, `WDC_IDX_CTRL, 0); chk(rd, 32'he0);
         chk(stop_mode, 1'b0);
         $display("test stop_irq done");
      end
   endtask
   task t_reset_mode;
      begin
         rst(1, 1);
         xfer(0, `WDC_IDX_CTRL, 0); chk(rd, 32'h20);
         wait_pulse(4300);
         chk({srst, srec, irq}, 3'b100);
         xfer(0, `WDC_IDX_CTRL, 0); chk(rd, 32'ha0);
         chk(rst_count, 8'h01);
         stop_cmd <= 1'b1;
         @(posedge clock);
         stop_cmd <= 1'b0;
         wait_pulse(4300);
         chk({srst, srec, irq}, 3'b010);
         xfer(0, `WDC_IDX_CTRL, 0); chk(rd, 32'he0);
         $display("test reset_mode done");
      end
   endtask
   task complete_run;
      begin
         $display("checked=%0d mismatches=%0d", checked, mismatches);
         if (mismatches == 0 && checked > 0) $display("NO MISMATCHES");
         else $display("MISMATCHES SEEN");
         $finish;
      end
   endtask
   // the whole sequence needs about ten thousand cycles
   initial begin
      #3000000;
      mismatches = mismatches + 1;
      complete_run;
   end
   initial begin
      t_off;
      t_lock;
      t_irq;
      t_stop_irq;
      t_reset_mode;
      complete_run;
   end
endmodule
